// ===== src/bcd_to_bin.sv
// bcd_to_bin: combinational decimal word to binary value, with a bad-digit flag
// assumes: digits packed four bits each, most significant digit highest
`timescale 1ns/1ps
`default_nettype none
module bcd_to_bin
  import word_alu_pkg::*;
#(
  parameter int DIGITS = 4,
  parameter int BITS   = 14
) (
  input  wire logic [DIGITS*4-1:0] bcd_in,
  output logic      [BITS-1:0]     bin_out,
  output logic                     bad_digit_out
);

  localparam logic [BITS-1:0] TEN = BITS'(10);

  // ==========================================================================
  // horner accumulation, most significant digit first
  always_comb begin
    logic [3:0] d;
    d = 4'h0;
    bin_out = '0;
    bad_digit_out = 1'b0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      d = bcd_in[i*4 +: 4];
      bin_out = BITS'(bin_out * TEN) + BITS'(d);
      if (d > DIGIT_MAX) begin
        bad_digit_out = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/bin_to_bcd.sv
// bin_to_bcd: combinational binary to packed decimal digits by shift-and-add-three
// assumes: the input value fits in DIGITS decimal digits
`timescale 1ns/1ps
`default_nettype none
module bin_to_bcd
  import word_alu_pkg::*;
#(
  parameter int BITS   = 27,
  parameter int DIGITS = 8
) (
  input  wire logic [BITS-1:0]     bin_in,
  output logic      [DIGITS*4-1:0] bcd_out
);

  // ==========================================================================
  // double dabble: correct digits of five or more, then shift a bit in
  always_comb begin
    bcd_out = '0;
    for (int i = BITS - 1; i >= 0; i--) begin
      for (int j = 0; j < DIGITS; j++) begin
        if (bcd_out[j*4 +: 4] >= DABBLE_LIMIT) begin
          bcd_out[j*4 +: 4] = bcd_out[j*4 +: 4] + DABBLE_ADD;
        end
      end
      bcd_out = {bcd_out[DIGITS*4-2:0], bin_in[i]};
    end
  end

endmodule
`default_nettype wire

// ===== src/word_alu_pkg.sv
// word_alu_pkg: widths, opcodes, limits and reset values for the word/bcd execution unit
// assumes: included by every design file of the unit through a whole-package import
package word_alu_pkg;

  // ==========================================================================
  // widths
  localparam int WORD_W      = 16;  // operand and result word
  localparam int BCD_DIGITS  = 4;   // digits in one decimal word
  localparam int DEC_BIN_W   = 14;  // binary width of 0..9999
  localparam int PROD_W      = 27;  // binary width of 9999*9999
  localparam int PROD_DIGITS = 8;   // digits in a two-word decimal product
  localparam int ADDR_W      = 14;  // data memory word number, binary

  // ==========================================================================
  // opcodes presented by the sequencer
  localparam logic [3:0] OP_MOVE_INV  = 4'h0;  // move_inverted_op
  localparam logic [3:0] OP_DEC_TO_R2 = 4'h1;  // decimal_to_radix2_op
  localparam logic [3:0] OP_R2_TO_DEC = 4'h2;  // binary to decimal
  localparam logic [3:0] OP_SHL_ZERO  = 4'h3;  // shift_left_zero_fill
  localparam logic [3:0] OP_SHR_ZERO  = 4'h4;  // shift_right_zero_fill
  localparam logic [3:0] OP_ROL_FLAG  = 4'h5;  // rotate_left_through_flag
  localparam logic [3:0] OP_ROR_FLAG  = 4'h6;  // rotate_right_through_flag
  localparam logic [3:0] OP_INVERT    = 4'h7;  // invert_word_op
  localparam logic [3:0] OP_DEC_SUM   = 4'h8;  // decimal sum with carry
  localparam logic [3:0] OP_DEC_DIFF  = 4'h9;  // decimal difference with borrow
  localparam logic [3:0] OP_DEC_PROD  = 4'ha;  // decimal_product_op
  localparam logic [3:0] OP_DEC_QUOT  = 4'hb;  // decimal quotient and remainder
  localparam logic [3:0] OP_AND_WORD  = 4'hc;  // bitwise_conjunction_op

  // ==========================================================================
  // limits of the data memory area and of decimal values
  localparam logic [ADDR_W-1:0] RW_LAST_ADDR  = 14'h03e7;  // word 0999
  localparam logic [ADDR_W-1:0] RO_LAST_ADDR  = 14'h07cf;  // word 1999
  localparam logic [PROD_W-1:0] DEC_MAX       = 27'h000270f;  // 9999
  localparam logic [PROD_W-1:0] DEC_MODULUS   = 27'h0002710;  // 10000
  localparam logic [3:0]        DIGIT_MAX     = 4'h9;
  localparam logic [3:0]        DABBLE_LIMIT  = 4'h5;
  localparam logic [3:0]        DABBLE_ADD    = 4'h3;

  // ==========================================================================
  // cycle counts and reset values
  localparam logic [3:0]        DIV_LAST_STEP = 4'hd;  // 14 restoring steps, 0..13
  localparam logic [WORD_W-1:0] RESULT_RST    = 16'h0000;
  localparam logic              CARRY_RST     = 1'b0;

endpackage

// ===== src/word_bcd_arith_logic_unit.sv
// word_bcd_arith_logic_unit: word and decimal execution unit for the controller's data ops
// assumes: sequencer on clk_in presents opcode and operands with a one-cycle start pulse
`timescale 1ns/1ps
`default_nettype none
module word_bcd_arith_logic_unit
  import word_alu_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              start_in,
  input  wire logic [3:0]        opcode_in,
  input  wire logic [WORD_W-1:0] op_a_in,
  input  wire logic [WORD_W-1:0] op_b_in,
  input  wire logic [ADDR_W-1:0] dest_addr_in,
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   error_out,
  output logic                   write_en_out,
  output logic                   write_two_out,
  output logic      [WORD_W-1:0] result_lo_out,
  output logic      [WORD_W-1:0] result_hi_out,
  output logic                   carry_flag_out
);

  typedef enum logic [1:0] {st_idle, st_div, st_div_end} state_e;

  // ==========================================================================
  // state
  state_e                 state;
  state_e                 next_state;
  logic [3:0]             step;
  logic [3:0]             next_step;
  logic [DEC_BIN_W-1:0]   dvd;
  logic [DEC_BIN_W-1:0]   next_dvd;
  logic [DEC_BIN_W-1:0]   dvs;
  logic [DEC_BIN_W-1:0]   next_dvs;
  logic [DEC_BIN_W-1:0]   rem;
  logic [DEC_BIN_W-1:0]   next_rem;
  logic [DEC_BIN_W-1:0]   quo;
  logic [DEC_BIN_W-1:0]   next_quo;
  logic [ADDR_W-1:0]      dest;
  logic [ADDR_W-1:0]      next_dest;
  logic                   next_busy;
  logic                   next_done;
  logic                   next_error;
  logic                   next_we;
  logic                   next_two;
  logic [WORD_W-1:0]      next_lo;
  logic [WORD_W-1:0]      next_hi;
  logic                   next_carry;

  // ==========================================================================
  // operand conversion
  logic [DEC_BIN_W-1:0]   a_bin;
  logic [DEC_BIN_W-1:0]   b_bin;
  logic                   a_bad;
  logic                   b_bad;
  logic [PROD_W-1:0]      conv_in;
  logic [PROD_DIGITS*4-1:0] conv_out;
  logic [BCD_DIGITS*4-1:0]  rem_bcd;
  logic [PROD_W-1:0]      sum_raw;
  logic [PROD_W-1:0]      sub_need;
  logic                   sum_carry;
  logic                   sub_borrow;

  bcd_to_bin #(.DIGITS(BCD_DIGITS), .BITS(DEC_BIN_W)) u_conv_a (
    .bcd_in        (op_a_in),
    .bin_out       (a_bin),
    .bad_digit_out (a_bad)
  );

  bcd_to_bin #(.DIGITS(BCD_DIGITS), .BITS(DEC_BIN_W)) u_conv_b (
    .bcd_in        (op_b_in),
    .bin_out       (b_bin),
    .bad_digit_out (b_bad)
  );

  bin_to_bcd #(.BITS(PROD_W), .DIGITS(PROD_DIGITS)) u_conv_res (
    .bin_in  (conv_in),
    .bcd_out (conv_out)
  );

  bin_to_bcd #(.BITS(DEC_BIN_W), .DIGITS(BCD_DIGITS)) u_conv_rem (
    .bin_in  (rem),
    .bcd_out (rem_bcd)
  );

  // ==========================================================================
  // binary value handed to the decimal converter
  always_comb begin
    sum_raw = 27'(a_bin) + 27'(b_bin) + 27'(carry_flag_out);
    sub_need = 27'(b_bin) + 27'(carry_flag_out);
    sum_carry = (sum_raw > DEC_MAX);
    sub_borrow = (27'(a_bin) < sub_need);
    conv_in = '0;
    if (state != st_idle) begin
      conv_in = 27'(quo);
    end else begin
      unique case (opcode_in)
        OP_R2_TO_DEC: conv_in = 27'(op_a_in);
        OP_DEC_SUM:   conv_in = sum_carry ? sum_raw - DEC_MODULUS : sum_raw;
        OP_DEC_DIFF:  conv_in = sub_borrow ? DEC_MODULUS + 27'(a_bin) - sub_need
                                           : 27'(a_bin) - sub_need;
        OP_DEC_PROD:  conv_in = 27'(a_bin) * 27'(b_bin);
        default:      conv_in = '0;
      endcase
    end
  end

  // ==========================================================================
  // next values: one-cycle ops, divider steps and result registers
  always_comb begin
    logic [DEC_BIN_W:0] trial;
    logic               ok_one;
    logic               ok_two;
    trial = '0;
    ok_one = (dest_addr_in <= RW_LAST_ADDR);
    ok_two = (dest_addr_in < RW_LAST_ADDR);
    next_state = state;
    next_step = step;
    next_dvd = dvd;
    next_dvs = dvs;
    next_rem = rem;
    next_quo = quo;
    next_dest = dest;
    next_busy = 1'b0;
    next_done = 1'b0;
    next_error = 1'b0;
    next_we = 1'b0;
    next_two = 1'b0;
    next_lo = result_lo_out;
    next_hi = result_hi_out;
    next_carry = carry_flag_out;
    unique case (state)
      st_idle: begin
        if (start_in) begin
          next_dest = dest_addr_in;
          next_done = 1'b1;
          next_we = ok_one;
          unique case (opcode_in)
            OP_MOVE_INV, OP_INVERT: begin
              next_lo = ~op_a_in;
            end
            OP_DEC_TO_R2: begin
              next_lo = 16'(a_bin);
            end
            OP_R2_TO_DEC: begin
              next_lo = conv_out[WORD_W-1:0];
            end
            OP_SHL_ZERO: begin
              next_lo = {op_a_in[WORD_W-2:0], 1'b0};
              next_carry = op_a_in[WORD_W-1];
            end
            OP_SHR_ZERO: begin
              next_lo = {1'b0, op_a_in[WORD_W-1:1]};
              next_carry = op_a_in[0];
            end
            OP_ROL_FLAG: begin
              next_lo = {op_a_in[WORD_W-2:0], carry_flag_out};
              next_carry = op_a_in[WORD_W-1];
            end
            OP_ROR_FLAG: begin
              next_lo = {carry_flag_out, op_a_in[WORD_W-1:1]};
              next_carry = op_a_in[0];
            end
            OP_DEC_SUM: begin
              next_lo = conv_out[WORD_W-1:0];
              next_carry = sum_carry;
            end
            OP_DEC_DIFF: begin
              next_lo = conv_out[WORD_W-1:0];
              next_carry = sub_borrow;
            end
            OP_DEC_PROD: begin
              next_lo = conv_out[WORD_W-1:0];
              next_hi = conv_out[2*WORD_W-1:WORD_W];
              next_we = ok_two;
              next_two = ok_two;
            end
            OP_DEC_QUOT: begin
              next_done = 1'b0;
              next_we = 1'b0;
              next_busy = 1'b1;
              next_state = st_div;
              next_step = '0;
              next_dvd = a_bin;
              next_dvs = b_bin;
              next_rem = '0;
              next_quo = '0;
            end
            OP_AND_WORD: begin
              next_lo = op_a_in & op_b_in;
            end
            default: begin
              next_we = 1'b0;
              next_error = 1'b1;
            end
          endcase
          // decimal faults and bad destinations abandon the op untouched
          if (((opcode_in == OP_DEC_TO_R2) && a_bad) ||
              ((opcode_in == OP_R2_TO_DEC) && (27'(op_a_in) > DEC_MAX)) ||
              ((opcode_in inside {OP_DEC_SUM, OP_DEC_DIFF, OP_DEC_PROD, OP_DEC_QUOT}) &&
               (a_bad || b_bad)) ||
              ((opcode_in == OP_DEC_QUOT) && (b_bin == '0)) ||
              ((opcode_in == OP_DEC_PROD || opcode_in == OP_DEC_QUOT) ? !ok_two
                                                                      : !ok_one)) begin
            next_state = st_idle;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_error = 1'b1;
            next_we = 1'b0;
            next_two = 1'b0;
            next_lo = result_lo_out;
            next_hi = result_hi_out;
            next_carry = carry_flag_out;
          end
        end
      end
      st_div: begin
        // one restoring step per cycle, most significant dividend bit first
        next_busy = 1'b1;
        trial = {rem, dvd[DEC_BIN_W-1]};
        next_dvd = {dvd[DEC_BIN_W-2:0], 1'b0};
        if (trial >= {1'b0, dvs}) begin
          trial = trial - {1'b0, dvs};
          next_quo = {quo[DEC_BIN_W-2:0], 1'b1};
        end else begin
          next_quo = {quo[DEC_BIN_W-2:0], 1'b0};
        end
        next_rem = trial[DEC_BIN_W-1:0];
        next_step = 4'(step + 4'h1);
        if (step == DIV_LAST_STEP) begin
          next_state = st_div_end;
        end
      end
      st_div_end: begin
        next_state = st_idle;
        next_done = 1'b1;
        next_we = 1'b1;
        next_two = 1'b1;
        next_lo = conv_out[WORD_W-1:0];
        next_hi = rem_bcd;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= st_idle;
      step <= '0;
      dvd <= '0;
      dvs <= '0;
      rem <= '0;
      quo <= '0;
      dest <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
      write_en_out <= 1'b0;
      write_two_out <= 1'b0;
      result_lo_out <= RESULT_RST;
      result_hi_out <= RESULT_RST;
      carry_flag_out <= CARRY_RST;
    end else begin
      state <= next_state;
      step <= next_step;
      dvd <= next_dvd;
      dvs <= next_dvs;
      rem <= next_rem;
      quo <= next_quo;
      dest <= next_dest;
      busy_out <= next_busy;
      done_out <= next_done;
      error_out <= next_error;
      write_en_out <= next_we;
      write_two_out <= next_two;
      result_lo_out <= next_lo;
      result_hi_out <= next_hi;
      carry_flag_out <= next_carry;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic take;
  logic fits_one;
  logic fits_two;
  // request taken this edge, and whether its destination is writable
  assign take     = start_in && (state == st_idle);
  assign fits_one = (dest_addr_in <= RW_LAST_ADDR);
  assign fits_two = (dest_addr_in < RW_LAST_ADDR);
  chk_move_inverse: assert property (take && opcode_in == OP_MOVE_INV |=>
      done_out && (write_en_out == ($past(dest_addr_in) <= RW_LAST_ADDR)) &&
      (result_lo_out == (write_en_out ? ~$past(op_a_in) : $past(result_lo_out))))
    else $error("move inverted result wrong");
  chk_shift_left: assert property (take && opcode_in == OP_SHL_ZERO && fits_one |=>
      result_lo_out == {$past(op_a_in[14:0]), 1'b0} && carry_flag_out == $past(op_a_in[15]))
    else $error("shift left result wrong");
  chk_shift_right: assert property (take && opcode_in == OP_SHR_ZERO && fits_one |=>
      result_lo_out == {1'b0, $past(op_a_in[15:1])} && carry_flag_out == $past(op_a_in[0]))
    else $error("shift right result wrong");
  chk_rotate_left: assert property (take && opcode_in == OP_ROL_FLAG && fits_one |=>
      result_lo_out == {$past(op_a_in[14:0]), $past(carry_flag_out)} &&
      carry_flag_out == $past(op_a_in[15]))
    else $error("rotate left through carry wrong");
  chk_rotate_right: assert property (take && opcode_in == OP_ROR_FLAG && fits_one |=>
      result_lo_out == {$past(carry_flag_out), $past(op_a_in[15:1])} &&
      carry_flag_out == $past(op_a_in[0]))
    else $error("rotate right through carry wrong");
  chk_and_word: assert property (take && opcode_in == OP_AND_WORD && fits_one |=>
      result_lo_out == ($past(op_a_in) & $past(op_b_in)) && write_en_out)
    else $error("word conjunction wrong");
  chk_sum_carry: assert property (take && opcode_in == OP_DEC_SUM && !a_bad && !b_bad &&
      fits_one |=> carry_flag_out == ($past(sum_raw) > DEC_MAX))
    else $error("decimal carry out wrong");
  chk_zero_divisor: assert property (take && opcode_in == OP_DEC_QUOT && b_bin == '0 |=>
      done_out && error_out && !write_en_out && $stable(result_lo_out))
    else $error("zero divisor not refused");
  // a write only ever comes with the finishing pulse of an accepted op
  chk_write_area: assert property (write_en_out |-> done_out && !error_out &&
      (write_two_out ? dest < RW_LAST_ADDR : dest <= RW_LAST_ADDR))
    else $error("write outside writable area");
  chk_div_latency: assert property (take && opcode_in == OP_DEC_QUOT && !a_bad &&
      !b_bad && b_bin != '0 && fits_two |=> busy_out [*8] ##1 busy_out [*7] ##1
      (done_out && write_en_out && write_two_out && !busy_out))
    else $error("divide did not finish in sixteen cycles");

endmodule
`default_nettype wire

// ===== verif/data_memory_model.sv
// data_memory_model: operand memory behind the unit, takes its result writes
// assumes: wired to the unit's ports by name, one clock shared with the unit
`timescale 1ns/1ps
`default_nettype none
module data_memory_model
  import word_alu_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              start_in,
  input  wire logic              busy_in,
  input  wire logic [ADDR_W-1:0] dest_addr_in,
  input  wire logic              write_en_in,
  input  wire logic              write_two_in,
  input  wire logic [WORD_W-1:0] lo_in,
  input  wire logic [WORD_W-1:0] hi_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [WORD_W-1:0] rd_data_out,
  output logic                   bad_write_out
);
  logic [WORD_W-1:0] mem [0:999];
  logic [ADDR_W-1:0] dest;
  // ==========================================================================
  // storage
  initial bad_write_out = 1'b0;
  // latch the destination when a request is taken, store results on a write
  always @(posedge clk_in) begin
    if (start_in && !busy_in) dest <= dest_addr_in;
    if (write_en_in) begin
      if (dest > RW_LAST_ADDR || (write_two_in && dest == RW_LAST_ADDR)) begin
        bad_write_out <= 1'b1;  // write into read-only area
      end else begin
        mem[dest] <= lo_in;
        if (write_two_in) mem[dest + 14'h0001] <= hi_in;
      end
    end
  end
  // read port for the bench
  assign rd_data_out = mem[rd_addr_in];
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// tb_top: self-checking bench of the word and decimal execution unit
// assumes: data_memory_model stands in for the operand memory
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import word_alu_pkg::*;
;
  logic              clk_in = 1'b0;
  logic              rst = 1'b1;
  logic              start = 1'b0;
  logic [3:0]        opcode = 4'h0;
  logic [WORD_W-1:0] op_a = 16'h0000;
  logic [WORD_W-1:0] op_b = 16'h0000;
  logic [ADDR_W-1:0] dest = 14'h0000;
  logic [ADDR_W-1:0] rd_addr = 14'h0000;
  logic [WORD_W-1:0] rd_data;
  logic              busy_out, done_out, error_out, we, two, cy, bad_write;
  logic [WORD_W-1:0] lo, hi;
  int                err_count = 0;
  int                checked = 0;
  int                cycles_run = 0;
  // ==========================================================================
  // clock, design and memory model
  always #4 clk_in = ~clk_in;
  word_bcd_arith_logic_unit i_dut (.clk_in(clk_in), .sys_rst_in(rst), .start_in(start),
    .opcode_in(opcode), .op_a_in(op_a), .op_b_in(op_b), .dest_addr_in(dest),
    .busy_out(busy_out), .done_out(done_out), .error_out(error_out), .write_en_out(we),
    .write_two_out(two), .result_lo_out(lo), .result_hi_out(hi), .carry_flag_out(cy));
  data_memory_model i_mem (.clk_in(clk_in), .start_in(start), .busy_in(busy_out),
    .dest_addr_in(dest), .write_en_in(we), .write_two_in(two), .lo_in(lo), .hi_in(hi),
    .rd_addr_in(rd_addr), .rd_data_out(rd_data), .bad_write_out(bad_write));
  // ==========================================================================
  // shared tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, then compare flags {err,we,two,cy}, answer delay and result words
  task automatic do_op(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b,
                       input logic [13:0] d, input logic [15:0] elo, input logic [15:0] ehi,
                       input logic [3:0] ef);
    int n;
    @(posedge clk_in);
    start <= 1'b1;
    opcode <= op;
    op_a <= a;
    op_b <= b;
    dest <= d;
    @(posedge clk_in);
    start <= 1'b0;
    n = 1;
    #1;
    while (done_out !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({error_out, we, two, cy, 12'(n), lo, (two ? hi : 16'h0)},
        {ef, ((op == OP_DEC_QUOT && !ef[3]) ? 12'h010 : 12'h001), elo, ehi});
  endtask
  task automatic mem_chk(input logic [13:0] a, input logic [15:0] e);
    @(posedge clk_in);
    rd_addr <= a;
    #1;
    chk({32'h0, rd_data}, {32'h0, e});
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_logic;
    do_op(OP_MOVE_INV, 16'h5a0f, 16'h0, 14'h0001, 16'ha5f0, 16'h0, 4'h4);
    do_op(OP_INVERT, 16'hffff, 16'h0, 14'h0002, 16'h0000, 16'h0, 4'h4);
    do_op(OP_AND_WORD, 16'hf0f0, 16'h3c3c, 14'h0003, 16'h3030, 16'h0, 4'h4);
    mem_chk(14'h0001, 16'ha5f0);
    $display("test logic done");
  endtask
  task automatic t_conv;
    do_op(OP_DEC_TO_R2, 16'h9999, 16'h0, 14'h0004, 16'h270f, 16'h0, 4'h4);
    do_op(OP_DEC_TO_R2, 16'h1a00, 16'h0, 14'h0004, 16'h270f, 16'h0, 4'h8);
    do_op(OP_R2_TO_DEC, 16'h04d2, 16'h0, 14'h0005, 16'h1234, 16'h0, 4'h4);
    do_op(OP_R2_TO_DEC, 16'h2710, 16'h0, 14'h0005, 16'h1234, 16'h0, 4'h8);
    $display("test conversion done");
  endtask
  task automatic t_shift;
    do_op(OP_SHL_ZERO, 16'h8001, 16'h0, 14'h0006, 16'h0002, 16'h0, 4'h5);
    do_op(OP_SHR_ZERO, 16'h8002, 16'h0, 14'h0006, 16'h4001, 16'h0, 4'h4);
    do_op(OP_ROL_FLAG, 16'h8000, 16'h0, 14'h0006, 16'h0000, 16'h0, 4'h5);
    do_op(OP_ROL_FLAG, 16'h4000, 16'h0, 14'h0006, 16'h8001, 16'h0, 4'h4);
    do_op(OP_ROR_FLAG, 16'h0001, 16'h0, 14'h0006, 16'h0000, 16'h0, 4'h5);
    do_op(OP_ROR_FLAG, 16'h0002, 16'h0, 14'h0006, 16'h8001, 16'h0, 4'h4);
    $display("test shift done");
  endtask
  task automatic t_decimal;
    do_op(OP_SHL_ZERO, 16'h8000, 16'h0, 14'h0007, 16'h0000, 16'h0, 4'h5);
    do_op(OP_DEC_SUM, 16'h9999, 16'h0000, 14'h0007, 16'h0000, 16'h0, 4'h5);
    do_op(OP_DEC_SUM, 16'h1234, 16'h4321, 14'h0007, 16'h5556, 16'h0, 4'h4);
    do_op(OP_DEC_DIFF, 16'h0000, 16'h0001, 14'h0008, 16'h9999, 16'h0, 4'h5);
    do_op(OP_DEC_DIFF, 16'h5000, 16'h1234, 14'h0008, 16'h3765, 16'h0, 4'h4);
    do_op(OP_DEC_PROD, 16'h9999, 16'h9999, 14'h03e6, 16'h0001, 16'h9998, 4'h6);
    do_op(OP_DEC_QUOT, 16'h9999, 16'h0007, 14'h03e4, 16'h1428, 16'h0003, 4'h6);
    $display("test decimal done");
  endtask
  task automatic t_refuse;
    do_op(OP_AND_WORD, 16'hffff, 16'h00ff, 14'h03e8, 16'h1428, 16'h0, 4'h8);
    do_op(OP_AND_WORD, 16'hffff, 16'h00ff, 14'h03e7, 16'h00ff, 16'h0, 4'h4);
    do_op(OP_DEC_PROD, 16'h0002, 16'h0003, 14'h03e7, 16'h00ff, 16'h0, 4'h8);
    do_op(OP_DEC_QUOT, 16'h1234, 16'h0000, 14'h0009, 16'h00ff, 16'h0, 4'h8);
    do_op(OP_DEC_SUM, 16'h00a0, 16'h0001, 14'h0009, 16'h00ff, 16'h0, 4'h8);
    do_op(4'hf, 16'h0001, 16'h0001, 14'h0009, 16'h00ff, 16'h0, 4'h8);
    mem_chk(14'h03e5, 16'h0003);
    mem_chk(14'h03e4, 16'h1428);
    mem_chk(14'h03e6, 16'h0001);
    mem_chk(14'h03e7, 16'h00ff);
    chk({47'h0, bad_write}, 48'h0);
    $display("test refusal done");
  endtask
  // ==========================================================================
  // watchdog and main sequence
  always @(posedge clk_in) begin
    cycles_run++;
    if (cycles_run == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst <= 1'b0;
    t_logic();
    t_conv();
    t_shift();
    t_decimal();
    t_refuse();
    complete_run();
  end
endmodule
`default_nettype wire
